// ===== logic/sfp_consts.vh
`ifndef SFP_CONSTS_VH
`define SFP_CONSTS_VH

// Instruction codes understood by the front end.
`define SFP_OP_WEN    8'h06
`define SFP_OP_WRDI   8'h04
`define SFP_OP_RDSR   8'h05
`define SFP_OP_RDSR2  8'h35
`define SFP_OP_WRSR   8'h01
`define SFP_OP_READ   8'h03
`define SFP_OP_DREAD  8'h3B
`define SFP_OP_QREAD  8'hEB
`define SFP_OP_PP     8'h02
`define SFP_OP_QPP    8'h32
`define SFP_OP_SE     8'h20
`define SFP_OP_HBE    8'h52
`define SFP_OP_BE     8'hD8
`define SFP_OP_CE     8'hC7
`define SFP_OP_SLP    8'hB9
`define SFP_OP_WAKE   8'hAB

// Status register 1 field positions.
`define SFP_SR1_WIP   0
`define SFP_SR1_WEL   1
`define SFP_SR1_RG0   2
`define SFP_SR1_RG2   4
`define SFP_SR1_BOT   5
`define SFP_SR1_SG    6
`define SFP_SR1_LOCK  7
// Status register 2 field positions.
`define SFP_SR2_LOCKH 0
`define SFP_SR2_QEN   1

// Reset values; the quad enable bit comes up as 0.
`define SFP_SR1_RST   8'h00
`define SFP_SR2_RST   8'h00

// Dummy clock counts between address (or, for wake, the command) and data.
`define SFP_DUMMY_DREAD 5'd8
`define SFP_DUMMY_QREAD 5'd6
`define SFP_DUMMY_WAKE  5'd24

// Array geometry.
`define SFP_ADDR_W      21
`define SFP_ARRAY_TOP   22'h20_0000
`define SFP_GRAN_4K     22'h00_1000
`define SFP_GRAN_64K    22'h01_0000

// Erase kinds.
`define SFP_ER_SECTOR   2'd0
`define SFP_ER_HALF     2'd1
`define SFP_ER_BLOCK    2'd2
`define SFP_ER_CHIP     2'd3

`endif

// ===== logic/sfp_sync.v
`timescale 1ns/10ps
// Two-stage synchroniser for levels arriving from outside the clock domain.
module sfp_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk_i,
  input  wire         sys_rst_i,
  // Data
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= d_i[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign q_o = sync_q;

endmodule

// ===== logic/sfp_pin_if.v
`timescale 1ns/10ps
`include "sfp_consts.vh"

module sfp_pin_if #(
  parameter [7:0] DEV_ID = 8'h5A  // Arbitrary identification value.
) (
  // Clock and reset
  input  wire                   clk_i,
  input  wire                   sys_rst_i,
  // Serial link pins
  input  wire                   sclk_i,
  input  wire                   chip_sel_n_i,
  input  wire                   io_lane_0_i,
  input  wire                   io_lane_1_i,
  input  wire                   io_lane_2_i,
  input  wire                   io_lane_3_i,
  output wire                   io_lane_0_o,
  output wire                   io_lane_1_o,
  output wire                   io_lane_2_o,
  output wire                   io_lane_3_o,
  output wire                   io_lane_0_oe_o,
  output wire                   io_lane_1_oe_o,
  output wire                   io_lane_2_oe_o,
  output wire                   io_lane_3_oe_o,
  // Array port
  output wire [`SFP_ADDR_W-1:0] arr_addr_o,
  output wire                   arr_rd_o,
  input  wire [7:0]             arr_rdata_i,
  output wire                   arr_wr_o,
  output wire [7:0]             arr_wdata_o,
  output wire                   prog_commit_o,
  output wire                   erase_o,
  output wire [1:0]             erase_kind_o,
  input  wire                   arr_done_i,
  // Status
  output wire [7:0]             status1_o,
  output wire [7:0]             status2_o,
  output wire                   busy_o,
  output wire                   deep_sleep_o,
  output wire                   selected_o
);

  localparam [2:0] PH_IDLE  = 3'd0;
  localparam [2:0] PH_CMD   = 3'd1;
  localparam [2:0] PH_ADDR  = 3'd2;
  localparam [2:0] PH_DUMMY = 3'd3;
  localparam [2:0] PH_DIN   = 3'd4;
  localparam [2:0] PH_DOUT  = 3'd5;
  localparam [2:0] PH_SKIP  = 3'd6;

  // Shift one lane group into a byte, most significant bit first.
  function [7:0] shift_in;
    input [7:0] sh;
    input [2:0] lw;
    input [3:0] io;
    begin
      case (lw)
        3'd2:    shift_in = {sh[5:0], io[1:0]};
        3'd4:    shift_in = {sh[3:0], io};
        default: shift_in = {sh[6:0], io[0]};
      endcase
    end
  endfunction

  // Map the leading bits of a byte onto the lanes for the width in use.
  function [3:0] lane_bits;
    input [7:0] b;
    input [2:0] lw;
    begin
      case (lw)
        3'd2:    lane_bits = {2'b00, b[7:6]};
        3'd4:    lane_bits = b[7:4];
        default: lane_bits = {2'b00, b[7], 1'b0};
      endcase
    end
  endfunction

  // Range protection from the status bits.
  function is_prot;
    input [`SFP_ADDR_W-1:0] a;
    input [2:0]             bp;
    input                   bot;
    input                   sg;
    reg   [21:0]            sz;
    begin
      sz = (sg ? `SFP_GRAN_4K : `SFP_GRAN_64K) << (bp - 3'd1);
      if (bp == 3'd0)
        is_prot = 1'b0;
      else if (bp == 3'd7)
        is_prot = 1'b1;
      else if (bot)
        is_prot = ({1'b0, a} < sz);
      else
        is_prot = ({1'b0, a} >= (`SFP_ARRAY_TOP - sz));
    end
  endfunction

  wire [5:0] s_w;
  sfp_sync #(
    .W (6)
  ) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       ({sclk_i, chip_sel_n_i, io_lane_3_i, io_lane_2_i,
                 io_lane_1_i, io_lane_0_i}),
    .q_o       (s_w)
  );
  wire       s_sclk = s_w[5];
  wire       s_csn  = s_w[4];
  wire [3:0] s_io   = s_w[3:0];

  reg                   p_sclk_q;
  reg                   p_csn_q;
  reg                   seen_high_q;
  reg  [2:0]            ph_q;
  reg  [2:0]            lw_q;
  reg  [2:0]            dlw_q;
  reg  [3:0]            bit_q;
  reg  [7:0]            sh_q;
  reg  [7:0]            op_q;
  reg  [1:0]            abyte_q;
  reg  [`SFP_ADDR_W-1:0] addr_q;
  reg  [`SFP_ADDR_W-1:0] rp_q;
  reg  [4:0]            dcnt_q;
  reg  [8:0]            din_n_q;
  reg  [7:0]            pend1_q;
  reg  [7:0]            pend2_q;
  reg  [7:0]            osh_q;
  reg  [3:0]            obit_q;
  reg  [3:0]            olane_q;
  reg                   out_act_q;
  reg  [7:0]            nxt_q;
  reg                   rdv_q;
  reg  [7:0]            sr1_q;
  reg  [7:0]            sr2_q;
  reg                   sleep_q;
  reg                   pg_run_q;
  reg  [7:0]            pg_idx_q;
  reg  [12:0]           pg_base_q;
  reg  [255:0]          vmask_q;
  reg  [7:0]            pbuf [0:255];
  reg  [`SFP_ADDR_W-1:0] arr_addr_q;
  reg                   arr_rd_q;
  reg                   arr_wr_q;
  reg  [7:0]            arr_wdata_q;
  reg                   commit_q;
  reg                   erase_q;
  reg  [1:0]            ekind_q;

  wire quad_en = sr2_q[`SFP_SR2_QEN];
  wire [2:0] bp = sr1_q[`SFP_SR1_RG2:`SFP_SR1_RG0];
  wire from_bot = sr1_q[`SFP_SR1_BOT];
  wire sg      = sr1_q[`SFP_SR1_SG];
  wire wel     = sr1_q[`SFP_SR1_WEL];
  wire wip     = sr1_q[`SFP_SR1_WIP];
  // Pause and protect pins only mean something while quad mode is off.
  wire hold_w  = ~quad_en & ~s_io[3] & (ph_q != PH_IDLE);
  wire locked  = sr2_q[`SFP_SR2_LOCKH] |
                 (sr1_q[`SFP_SR1_LOCK] & ~s_io[2] & ~quad_en);
  wire rise    = s_sclk & ~p_sclk_q & ~hold_w;
  wire fall    = ~s_sclk & p_sclk_q & ~hold_w;
  wire cs_fall = p_csn_q & ~s_csn;
  wire cs_rise = s_csn & ~p_csn_q;
  wire [3:0] nbit = bit_q + {1'b0, lw_q};
  wire bdone   = (nbit == 4'd8);
  wire [7:0] bin = shift_in(sh_q, lw_q, s_io);
  wire is_pp   = (op_q == `SFP_OP_PP) | (op_q == `SFP_OP_QPP);
  wire is_rd   = (op_q == `SFP_OP_READ) | (op_q == `SFP_OP_DREAD) |
                 (op_q == `SFP_OP_QREAD);
  wire [`SFP_ADDR_W-1:0] new_addr = {addr_q[12:0], bin};
  wire [7:0] buf_wa = addr_q[7:0] + din_n_q[7:0];
  wire buf_we  = rise & (ph_q == PH_DIN) & bdone & is_pp &
                 (din_n_q != 9'h1FF);

  reg [7:0] src;
  always @* begin
    case (op_q)
      `SFP_OP_RDSR:  src = sr1_q;
      `SFP_OP_RDSR2: src = sr2_q;
      `SFP_OP_WAKE:  src = DEV_ID;
      default:       src = nxt_q;
    endcase
  end
  wire [7:0] ob     = (obit_q == 4'd0) ? src : osh_q;
  wire [3:0] ob_rem = ((obit_q == 4'd0) ? 4'd8 : obit_q) - {1'b0, lw_q};

  // The page buffer has no reset; only bytes flagged in vmask_q are used.
  always @(posedge clk_i) begin
    if (buf_we)
      pbuf[buf_wa] <= bin;
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      p_sclk_q    <= 1'b0;
      p_csn_q     <= 1'b0;
      seen_high_q <= 1'b0;
      ph_q        <= PH_IDLE;
      lw_q        <= 3'd1;
      dlw_q       <= 3'd1;
      bit_q       <= 4'd0;
      sh_q        <= 8'h00;
      op_q        <= 8'h00;
      abyte_q     <= 2'd0;
      addr_q      <= 21'h00_0000;
      rp_q        <= 21'h00_0000;
      dcnt_q      <= 5'd0;
      din_n_q     <= 9'h000;
      pend1_q     <= 8'h00;
      pend2_q     <= 8'h00;
      osh_q       <= 8'h00;
      obit_q      <= 4'd0;
      olane_q     <= 4'h0;
      out_act_q   <= 1'b0;
      nxt_q       <= 8'h00;
      rdv_q       <= 1'b0;
      sr1_q       <= `SFP_SR1_RST;
      sr2_q       <= `SFP_SR2_RST;
      sleep_q     <= 1'b0;
      pg_run_q    <= 1'b0;
      pg_idx_q    <= 8'h00;
      pg_base_q   <= 13'h0000;
      vmask_q     <= 256'd0;
      arr_addr_q  <= 21'h00_0000;
      arr_rd_q    <= 1'b0;
      arr_wr_q    <= 1'b0;
      arr_wdata_q <= 8'h00;
      commit_q    <= 1'b0;
      erase_q     <= 1'b0;
      ekind_q     <= `SFP_ER_SECTOR;
    end else begin
      p_sclk_q <= s_sclk;
      p_csn_q  <= s_csn;
      arr_rd_q <= 1'b0;
      arr_wr_q <= 1'b0;
      commit_q <= 1'b0;
      erase_q  <= 1'b0;
      rdv_q    <= arr_rd_q;
      if (rdv_q)
        nxt_q <= arr_rdata_i;
      if (s_csn)
        seen_high_q <= 1'b1;
      // Internal cycles run from here, independent of chip select.
      if (wip & arr_done_i & ~pg_run_q)
        sr1_q[`SFP_SR1_WIP] <= 1'b0;
      if (pg_run_q) begin
        arr_wr_q    <= vmask_q[pg_idx_q];
        arr_addr_q  <= {pg_base_q, pg_idx_q};
        arr_wdata_q <= pbuf[pg_idx_q];
        pg_idx_q    <= pg_idx_q + 8'd1;
        if (pg_idx_q == 8'hFF) begin
          pg_run_q <= 1'b0;
          commit_q <= 1'b1;
        end
      end
      if (cs_rise) begin
        ph_q      <= PH_IDLE;
        out_act_q <= 1'b0;
        // Only whole bytes with an accepted byte count execute at deselect.
        if (ph_q == PH_DIN && bit_q == 4'd0) begin
          case (op_q)
            `SFP_OP_WEN: if (din_n_q == 9'h000)
              sr1_q[`SFP_SR1_WEL] <= 1'b1;
            `SFP_OP_WRDI: if (din_n_q == 9'h000)
              sr1_q[`SFP_SR1_WEL] <= 1'b0;
            `SFP_OP_SLP: if (din_n_q == 9'h000)
              sleep_q <= 1'b1;
            `SFP_OP_WRSR: if (din_n_q != 9'h000 && wel) begin
              sr1_q[`SFP_SR1_WEL] <= 1'b0;
              if (!locked) begin
                sr1_q[7:2] <= pend1_q[7:2];
                if (din_n_q >= 9'd2)
                  sr2_q[1:0] <= pend2_q[1:0];
              end
            end
            `SFP_OP_PP, `SFP_OP_QPP:
              if (din_n_q != 9'h000 && wel &&
                  !is_prot(addr_q, bp, from_bot, sg)) begin
                pg_run_q            <= 1'b1;
                pg_idx_q            <= 8'h00;
                pg_base_q           <= addr_q[20:8];
                sr1_q[`SFP_SR1_WIP] <= 1'b1;
                sr1_q[`SFP_SR1_WEL] <= 1'b0;
              end
            `SFP_OP_SE, `SFP_OP_HBE, `SFP_OP_BE, `SFP_OP_CE:
              if (din_n_q == 9'h000 && wel &&
                  ((op_q == `SFP_OP_CE) ? (bp == 3'd0) :
                   !is_prot(addr_q, bp, from_bot, sg))) begin
                erase_q             <= 1'b1;
                sr1_q[`SFP_SR1_WIP] <= 1'b1;
                sr1_q[`SFP_SR1_WEL] <= 1'b0;
                case (op_q)
                  `SFP_OP_SE: begin
                    ekind_q    <= `SFP_ER_SECTOR;
                    arr_addr_q <= {addr_q[20:12], 12'h000};
                  end
                  `SFP_OP_HBE: begin
                    ekind_q    <= `SFP_ER_HALF;
                    arr_addr_q <= {addr_q[20:15], 15'h0000};
                  end
                  `SFP_OP_BE: begin
                    ekind_q    <= `SFP_ER_BLOCK;
                    arr_addr_q <= {addr_q[20:16], 16'h0000};
                  end
                  default: begin
                    ekind_q    <= `SFP_ER_CHIP;
                    arr_addr_q <= 21'h00_0000;
                  end
                endcase
              end
            default: ;
          endcase
        end
      end else if (cs_fall && seen_high_q) begin
        ph_q      <= PH_CMD;
        lw_q      <= 3'd1;
        bit_q     <= 4'd0;
        din_n_q   <= 9'h000;
        obit_q    <= 4'd0;
        out_act_q <= 1'b0;
      end else if (rise) begin
        case (ph_q)
          PH_CMD, PH_ADDR, PH_DIN: begin
            sh_q  <= bin;
            bit_q <= bdone ? 4'd0 : nbit;
          end
          default: ;
        endcase
        if (ph_q == PH_CMD && bdone) begin
          op_q    <= bin;
          abyte_q <= 2'd0;
          if ((sleep_q && bin != `SFP_OP_WAKE) ||
              (wip && bin != `SFP_OP_RDSR && bin != `SFP_OP_RDSR2))
            ph_q <= PH_SKIP;
          else begin
            case (bin)
              `SFP_OP_RDSR, `SFP_OP_RDSR2:
                ph_q <= PH_DOUT;
              `SFP_OP_WEN, `SFP_OP_WRDI, `SFP_OP_SLP, `SFP_OP_CE,
              `SFP_OP_WRSR:
                ph_q <= PH_DIN;
              `SFP_OP_READ, `SFP_OP_DREAD, `SFP_OP_PP, `SFP_OP_SE,
              `SFP_OP_HBE, `SFP_OP_BE:
                ph_q <= PH_ADDR;
              `SFP_OP_QREAD, `SFP_OP_QPP: begin
                ph_q <= quad_en ? PH_ADDR : PH_SKIP;
                lw_q <= (bin == `SFP_OP_QREAD) ? 3'd4 : 3'd1;
              end
              `SFP_OP_WAKE: begin
                sleep_q <= 1'b0;
                ph_q   <= PH_DUMMY;
                dcnt_q <= `SFP_DUMMY_WAKE;
                dlw_q  <= 3'd1;
              end
              default: ph_q <= PH_SKIP;
            endcase
          end
        end
        if (ph_q == PH_ADDR && bdone) begin
          addr_q  <= new_addr;
          abyte_q <= abyte_q + 2'd1;
          if (abyte_q == 2'd2) begin
            case (op_q)
              `SFP_OP_READ: begin
                ph_q       <= PH_DOUT;
                arr_rd_q   <= 1'b1;
                arr_addr_q <= new_addr;
                rp_q       <= new_addr + 21'h00_0001;
              end
              `SFP_OP_DREAD: begin
                ph_q   <= PH_DUMMY;
                dcnt_q <= `SFP_DUMMY_DREAD;
                dlw_q  <= 3'd2;
              end
              `SFP_OP_QREAD: begin
                ph_q   <= PH_DUMMY;
                dcnt_q <= `SFP_DUMMY_QREAD;
                dlw_q  <= 3'd4;
              end
              `SFP_OP_PP, `SFP_OP_QPP: begin
                ph_q    <= PH_DIN;
                lw_q    <= (op_q == `SFP_OP_QPP) ? 3'd4 : 3'd1;
                vmask_q <= 256'd0;
              end
              default: ph_q <= PH_DIN;
            endcase
          end
        end
        if (ph_q == PH_DIN && bdone) begin
          if (din_n_q != 9'h1FF)
            din_n_q <= din_n_q + 9'd1;
          if (buf_we)
            vmask_q[buf_wa] <= 1'b1;
          if (din_n_q == 9'h000)
            pend1_q <= bin;
          if (din_n_q == 9'h001)
            pend2_q <= bin;
        end
        if (ph_q == PH_DUMMY) begin
          dcnt_q <= dcnt_q - 5'd1;
          if (dcnt_q == 5'd1) begin
            ph_q <= PH_DOUT;
            lw_q <= dlw_q;
            if (is_rd) begin
              arr_rd_q   <= 1'b1;
              arr_addr_q <= addr_q;
              rp_q       <= addr_q + 21'h00_0001;
            end
          end
        end
      end else if (fall && ph_q == PH_DOUT) begin
        // Next bit group goes out on the falling edge.
        olane_q   <= lane_bits(ob, lw_q);
        osh_q     <= (lw_q == 3'd4) ? {ob[3:0], 4'h0} :
                     (lw_q == 3'd2) ? {ob[5:0], 2'b00} : {ob[6:0], 1'b0};
        obit_q    <= ob_rem;
        out_act_q <= 1'b1;
        // Prefetch the following byte; the address wraps at the array end.
        if (obit_q == 4'd0 && is_rd) begin
          arr_rd_q   <= 1'b1;
          arr_addr_q <= rp_q;
          rp_q       <= rp_q + 21'h00_0001;
        end
      end
    end
  end

  // Lanes are released whenever deselected or paused.
  wire drive = (ph_q == PH_DOUT) & out_act_q & ~hold_w & ~s_csn;
  assign io_lane_0_o    = olane_q[0];
  assign io_lane_1_o    = (lw_q == 3'd1) ? olane_q[1] : olane_q[1];
  assign io_lane_2_o    = olane_q[2];
  assign io_lane_3_o    = olane_q[3];
  assign io_lane_0_oe_o = drive & (lw_q != 3'd1);
  assign io_lane_1_oe_o = drive;
  assign io_lane_2_oe_o = drive & (lw_q == 3'd4);
  assign io_lane_3_oe_o = drive & (lw_q == 3'd4);

  assign arr_addr_o    = arr_addr_q;
  assign arr_rd_o      = arr_rd_q;
  assign arr_wr_o      = arr_wr_q;
  assign arr_wdata_o   = arr_wdata_q;
  assign prog_commit_o = commit_q;
  assign erase_o       = erase_q;
  assign erase_kind_o  = ekind_q;
  assign status1_o     = sr1_q;
  assign status2_o     = sr2_q;
  assign busy_o        = wip;
  assign deep_sleep_o  = sleep_q;
  assign selected_o    = (ph_q != PH_IDLE);

endmodule

// ===== test/sfp_pin_if_chk.sv
`timescale 1ns/10ps
`include "sfp_consts.vh"
module sfp_pin_if_chk (
  // Clock and reset
  input logic                   clk_i,
  input logic                   sys_rst_i,
  // Link pins
  input logic                   sclk_i,
  input logic                   chip_sel_n_i,
  input logic                   io_lane_3_i,
  input logic                   io_lane_1_o,
  input logic                   io_lane_0_oe_o,
  input logic                   io_lane_1_oe_o,
  input logic                   io_lane_2_oe_o,
  input logic                   io_lane_3_oe_o,
  // Array and status
  input logic [`SFP_ADDR_W-1:0] arr_addr_o,
  input logic                   arr_rd_o,
  input logic                   arr_wr_o,
  input logic                   erase_o,
  input logic [1:0]             erase_kind_o,
  input logic                   arr_done_i,
  input logic [7:0]             status1_o,
  input logic [7:0]             status2_o,
  input logic                   busy_o,
  input logic                   deep_sleep_o,
  input logic                   selected_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire any_oe = io_lane_0_oe_o | io_lane_1_oe_o | io_lane_2_oe_o |
                io_lane_3_oe_o;
  a_desel_float: assert property (chip_sel_n_i [*5] |-> !any_oe)
    else $error("lane driven while deselected");
  a_desel_idle: assert property (chip_sel_n_i [*5] |-> !selected_o)
    else $error("frame open while deselected");
  a_dual_pair: assert property (io_lane_0_oe_o |-> io_lane_1_oe_o)
    else $error("lane 0 driven without lane 1");
  a_quad_lanes: assert property ((io_lane_2_oe_o || io_lane_3_oe_o)
    |-> status2_o[`SFP_SR2_QEN]) else $error("upper lane driven off quad");
  a_pause_float: assert property (
    (!io_lane_3_i && !status2_o[`SFP_SR2_QEN]) [*5] |-> !io_lane_1_oe_o)
    else $error("output driven during pause");
  // The output may only move once the falling link edge is through sync.
  a_fall_launch: assert property (io_lane_1_oe_o && $past(io_lane_1_oe_o)
    && $changed(io_lane_1_o) |-> !$past(sclk_i, 2))
    else $error("output changed off falling edge");
  a_busy_hold: assert property (busy_o && !arr_done_i |=> busy_o)
    else $error("busy dropped without completion");
  a_erase_wel: assert property (erase_o |-> $past(status1_o[1], 2))
    else $error("erase without write enable");
  a_sector_align: assert property (erase_o &&
    erase_kind_o == `SFP_ER_SECTOR |-> arr_addr_o[11:0] == 12'h000)
    else $error("sector erase not aligned");
  a_prog_busy: assert property (arr_wr_o |-> busy_o)
    else $error("array write outside program cycle");
  a_sleep_quiet: assert property (deep_sleep_o |->
    !(arr_rd_o || arr_wr_o || erase_o)) else $error("array used in sleep");
endmodule

// ===== test/sfp_host_model.sv
`timescale 1ns/10ps
module sfp_host_model (
  // Clock
  input  logic       clk_i,
  // Link pins
  output logic       sclk_o,
  output logic       cs_n_o,
  output logic       mosi_o,
  output logic       hold_n_o,
  input  logic       miso_i,
  // Captured bytes
  output logic [7:0] rx_byte_o,
  output logic       rx_stb_o
);
  // Chip select starts low so the power-up rule can be exercised.
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    mosi_o = 1'b0;
    hold_n_o = 1'b1;
    rx_byte_o = 8'h00;
    rx_stb_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // The answer bit is taken late in the high phase, well after it settles.
  task automatic xb(input logic [7:0] tx, input logic cap,
                    output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_o <= tx[i];
      tick(4);
      sclk_o <= 1'b1;
      tick(4);
      rx[i] = miso_i;
      sclk_o <= 1'b0;
    end
    rx_byte_o <= rx;
    rx_stb_o <= cap;
    tick(1);
    rx_stb_o <= 1'b0;
  endtask
  task automatic frame_start();
    cs_n_o <= 1'b0;
    tick(8);
  endtask
  task automatic frame_end();
    tick(4);
    cs_n_o <= 1'b1;
    tick(16);
  endtask
  // Clock pulses sent while paused must leave the frame untouched.
  task automatic pause_burst();
    hold_n_o <= 1'b0;
    tick(8);
    repeat (8) begin
      sclk_o <= 1'b1;
      tick(4);
      sclk_o <= 1'b0;
      tick(4);
    end
    hold_n_o <= 1'b1;
    tick(8);
  endtask
endmodule

// ===== test/sfp_pin_if_bench.sv
`timescale 1ns/10ps
`include "sfp_consts.vh"
module sfp_pin_if_bench;
  localparam logic [7:0] ID = 8'hC3; // Arbitrary identification value.
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sclk, cs_n, mosi, hold_n, rx_stb, l1_last = 1'b0;
  logic [7:0] rx_byte, arr_rdata_i = 8'hFF, arr_wdata_o;
  logic [3:0] lo, loe;
  logic [20:0] arr_addr_o;
  logic arr_rd_o, arr_wr_o, prog_commit_o, erase_o, busy_o;
  logic arr_done_i = 1'b0;
  logic [1:0] erase_kind_o;
  logic [7:0] mem [0:8191];
  logic [7:0] expq [$];
  int done_cnt = 0;
  int n_fail = 0;
  int checks = 0;
  // Released lines: lane 0 carries mosi, lane 1 toggles, lane 2 is pulled up, lane 3 carries hold_n.
  wire l0 = loe[0] ? lo[0] : mosi;
  wire l1 = loe[1] ? lo[1] : ~l1_last;
  wire l2 = loe[2] ? lo[2] : 1'b1;
  wire l3 = loe[3] ? lo[3] : hold_n;
  always #2 clk_i = ~clk_i;
  sfp_host_model i_sfp_host_model (.clk_i(clk_i), .sclk_o(sclk),
    .cs_n_o(cs_n), .mosi_o(mosi), .hold_n_o(hold_n), .miso_i(l1),
    .rx_byte_o(rx_byte), .rx_stb_o(rx_stb));
  sfp_pin_if #(.DEV_ID(ID)) i_sfp_pin_if (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .sclk_i(sclk), .chip_sel_n_i(cs_n),
    .io_lane_0_i(l0), .io_lane_1_i(l1), .io_lane_2_i(l2), .io_lane_3_i(l3),
    .io_lane_0_o(lo[0]), .io_lane_1_o(lo[1]), .io_lane_2_o(lo[2]),
    .io_lane_3_o(lo[3]), .io_lane_0_oe_o(loe[0]), .io_lane_1_oe_o(loe[1]),
    .io_lane_2_oe_o(loe[2]), .io_lane_3_oe_o(loe[3]),
    .arr_addr_o(arr_addr_o), .arr_rd_o(arr_rd_o), .arr_rdata_i(arr_rdata_i),
    .arr_wr_o(arr_wr_o), .arr_wdata_o(arr_wdata_o),
    .prog_commit_o(prog_commit_o), .erase_o(erase_o),
    .erase_kind_o(erase_kind_o), .arr_done_i(arr_done_i), .status1_o(),
    .status2_o(), .busy_o(busy_o), .deep_sleep_o(), .selected_o());
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // Array model: slow completion so status can be read mid-cycle.
  always @(posedge clk_i) begin
    l1_last <= l1;
    arr_rdata_i <= mem[arr_addr_o[12:0]];
    if (arr_wr_o) mem[arr_addr_o[12:0]] <= mem[arr_addr_o[12:0]] & arr_wdata_o;
    if (erase_o) for (int k = 0; k < 4096; k++)
      mem[{arr_addr_o[12], k[11:0]}] <= 8'hFF;
    arr_done_i <= (done_cnt == 1);
    if (prog_commit_o || erase_o) done_cnt <= 400;
    else if (done_cnt > 0) done_cnt <= done_cnt - 1;
  end
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  always @(posedge clk_i) if (rx_stb) begin
    if (expq.size() == 0) n_fail++;
    else chk("lane byte", rx_byte, expq.pop_front());
  end
  task automatic cmd(input logic [7:0] op, input int n, input logic [23:0] a);
    logic [7:0] r;
    i_sfp_host_model.frame_start();
    i_sfp_host_model.xb(op, 1'b0, r);
    for (int i = 2; i >= 3 - n; i--) i_sfp_host_model.xb(a[8*i +: 8], 1'b0, r);
  endtask
  task automatic exp_byte(input logic [7:0] e);
    logic [7:0] r;
    expq.push_back(e);
    i_sfp_host_model.xb(8'h00, 1'b1, r);
  endtask
  task automatic fin();
    i_sfp_host_model.frame_end();
  endtask
  task automatic status(input logic [7:0] e);
    cmd(`SFP_OP_RDSR, 0, 24'h00_0000);
    exp_byte(e);
    fin();
  endtask
  task automatic wr_en();
    cmd(`SFP_OP_WEN, 0, 24'h00_0000);
    fin();
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 5000) n_fail++;
  endtask
  task automatic prog(input logic [23:0] a, input logic [7:0] b0, b1);
    logic [7:0] r;
    wr_en();
    cmd(`SFP_OP_PP, 3, a);
    i_sfp_host_model.xb(b0, 1'b0, r);
    i_sfp_host_model.xb(b1, 1'b0, r);
    fin();
    status(8'h01);
    wait_idle();
  endtask
  task automatic tally_and_finish();
    if (expq.size() != 0) n_fail++;
    if (n_fail == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100_000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] d0, d1;
    int seed;
    seed = 85;
    d0 = $random(seed);
    d1 = $random(seed);
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    wr_en();
    status(8'h00);
    wr_en();
    status(8'h02);
    // Drop the write enable so the erase below arrives without one.
    cmd(`SFP_OP_WRDI, 0, 24'h00_0000);
    fin();
    cmd(`SFP_OP_SE, 3, 24'h00_0100);
    fin();
    status(8'h00);
    // The second byte wraps to the start of the page.
    prog(24'h00_01FF, d0, d1);
    prog(24'h00_01FF, 8'hF0, 8'h0F);
    cmd(`SFP_OP_READ, 3, 24'h00_01FF);
    exp_byte(d0 & 8'hF0);
    exp_byte(8'hFF);
    fin();
    cmd(`SFP_OP_READ, 3, 24'h00_0100);
    i_sfp_host_model.pause_burst();
    exp_byte(d1 & 8'h0F);
    fin();
    wr_en();
    cmd(`SFP_OP_SE, 3, 24'h00_0100);
    fin();
    status(8'h01);
    wait_idle();
    cmd(`SFP_OP_READ, 3, 24'h00_01FF);
    exp_byte(8'hFF);
    fin();
    cmd(`SFP_OP_SLP, 0, 24'h00_0000);
    fin();
    wr_en();
    cmd(`SFP_OP_WAKE, 3, 24'h00_0000);
    exp_byte(ID);
    fin();
    status(8'h00);
    tally_and_finish();
  end
endmodule
bind sfp_pin_if sfp_pin_if_chk i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .sclk_i(sclk_i), .chip_sel_n_i(chip_sel_n_i), .io_lane_3_i(io_lane_3_i),
  .io_lane_1_o(io_lane_1_o), .io_lane_0_oe_o(io_lane_0_oe_o),
  .io_lane_1_oe_o(io_lane_1_oe_o), .io_lane_2_oe_o(io_lane_2_oe_o),
  .io_lane_3_oe_o(io_lane_3_oe_o), .arr_addr_o(arr_addr_o),
  .arr_rd_o(arr_rd_o), .arr_wr_o(arr_wr_o), .erase_o(erase_o),
  .erase_kind_o(erase_kind_o), .arr_done_i(arr_done_i),
  .status1_o(status1_o), .status2_o(status2_o), .busy_o(busy_o),
  .deep_sleep_o(deep_sleep_o), .selected_o(selected_o));
